// file: common/qpmii_defines.svh
`ifndef QPMII_DEFINES_SVH
`define QPMII_DEFINES_SVH

// ************************************************************
// sizes and rates
// ************************************************************
`define QPMII_PORTS 4
`define QPMII_NIB_W 4
`define QPMII_CORE_HZ 20000000
`define QPMII_RATE_100_HZ 25000000
`define QPMII_RATE_10_HZ 2500000

// half periods of the port clocks in core cycles, rounded down, never below one
`define QPMII_HALF_RAW(hz) (`QPMII_CORE_HZ / (2 * (hz)))
`define QPMII_HALF(hz) ((`QPMII_HALF_RAW(hz) < 1) ? 1 : `QPMII_HALF_RAW(hz))
`define QPMII_HALF_100 `QPMII_HALF(`QPMII_RATE_100_HZ)
`define QPMII_HALF_10 `QPMII_HALF(`QPMII_RATE_10_HZ)
`define QPMII_CNT_W 4

`endif

// file: common/qpmii_pkg.sv
package qpmii_pkg;

  // mac transmit pins of one port
  typedef struct packed {
    logic [3:0] txd;
    logic tx_en;
    logic tx_er;
  } qpmii_mii_tx_t;

  // mac receive pins of one port
  typedef struct packed {
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
  } qpmii_mii_rx_t;

  // decoded receive code group from the line coder
  typedef struct packed {
    logic [3:0] nibble;
    logic data_valid;
    logic code_bad;
    logic active;
  } qpmii_pcs_rx_t;

  // symbol handed to the line coder once per transmit clock
  typedef struct packed {
    logic strobe;
    logic valid;
    logic halt;
    logic [3:0] nibble;
  } qpmii_line_tx_t;

  // per port state of the data port
  typedef struct packed {
    qpmii_mii_tx_t sync0;
    qpmii_mii_tx_t sync1;
    logic rise_d;
    logic fall_d;
    logic tx_en;
    qpmii_line_tx_t line;
    qpmii_mii_rx_t rx;
    logic crs;
  } qpmii_port_st_t;

  typedef struct packed {
    logic [3:0] fast;
    logic [3:0] clk;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0][3:0] cnt;
  } qpmii_clk_st_t;

endpackage

// file: logic/qpmii_clkgen.sv
`include "qpmii_defines.svh"

// ************************************************************
// port clock divider
// ************************************************************
// one clock per port; the rate taken on at each toggle so a speed change
// never shortens a half period already running
module qpmii_clkgen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // rate select
  input wire logic i_fast,
  // port clock and its edge pulses
  output logic o_clk,
  output logic o_rise,
  output logic o_fall
);
  import qpmii_pkg::*;

  typedef struct packed {
    logic clk;
    logic rise;
    logic fall;
    logic [`QPMII_CNT_W-1:0] cnt;
  } qpmii_div_st_t;

  qpmii_div_st_t st_q, st_d;
  logic [`QPMII_CNT_W-1:0] half;

  // reload value for the next half period
  assign half = i_fast ? `QPMII_CNT_W'(`QPMII_HALF_100 - 1) : `QPMII_CNT_W'(`QPMII_HALF_10 - 1);

  // count down, toggle and flag the edge in the same cycle
  always_comb begin
    st_d = st_q;
    st_d.rise = 1'b0;
    st_d.fall = 1'b0;
    if (st_q.cnt == '0) begin
      st_d.clk = ~st_q.clk;
      st_d.rise = ~st_q.clk;
      st_d.fall = st_q.clk;
      st_d.cnt = half;
    end else begin
      st_d.cnt = st_q.cnt - `QPMII_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_clk = st_q.clk;
  assign o_rise = st_q.rise;
  assign o_fall = st_q.fall;

endmodule // qpmii_clkgen

// file: logic/qpmii_top.sv
`include "qpmii_defines.svh"

// ************************************************************
// four port mii data path, phy side
// ************************************************************

module qpmii_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // per port configuration
  input wire logic [3:0] i_speed_100,
  input wire logic [3:0] i_full_duplex,
  input wire logic [3:0] i_late_sample,
  // mac transmit side
  input wire qpmii_pkg::qpmii_mii_tx_t [3:0] i_mii_tx,
  output logic [3:0] o_tx_clk,
  // mac receive side
  output qpmii_pkg::qpmii_mii_rx_t [3:0] o_mii_rx,
  output logic [3:0] o_rx_clk,
  output logic [3:0] o_crs,
  // line coder side
  output qpmii_pkg::qpmii_line_tx_t [3:0] o_line_tx,
  input wire qpmii_pkg::qpmii_pcs_rx_t [3:0] i_pcs_rx,
  input wire logic [3:0] i_pll_lock
);
  import qpmii_pkg::*;

  typedef struct packed {
    qpmii_port_st_t [3:0] port;
  } qpmii_state_t;

  qpmii_state_t state_q, state_d;
  // nets, since each port's divider drives its own bit
  wire logic [3:0] pclk;
  wire logic [3:0] prise;
  wire logic [3:0] pfall;

  // ************************************************************
  // port clocks
  // ************************************************************
  // the receive clock shares the transmit divider; at this core rate the
  // 100 mbps clock can only run at half the core clock
  for (genvar g = 0; g < `QPMII_PORTS; g++) begin : g_clk
    qpmii_clkgen u_clkgen (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_fast(i_speed_100[g]),
      .o_clk(pclk[g]),
      .o_rise(prise[g]),
      .o_fall(pfall[g])
    );
  end

  // ************************************************************
  // data path
  // ************************************************************
  // pins are synchronised first; the edge pulse is delayed one cycle so it
  // lines up with the synchronised copy of the pin level at that edge
  always_comb begin
    state_d = state_q;
    for (int p = 0; p < `QPMII_PORTS; p++) begin
      state_d.port[p].sync0 = i_mii_tx[p];
      state_d.port[p].sync1 = state_q.port[p].sync0;
      state_d.port[p].rise_d = prise[p];
      state_d.port[p].fall_d = pfall[p];
      state_d.port[p].line.strobe = 1'b0;
      // late mode picks the falling edge instead of the rising one; the mode bit is
      // read at the strobe, so flipping it mid frame may drop or repeat one nibble
      if (i_late_sample[p] ? state_q.port[p].fall_d : state_q.port[p].rise_d) begin
        state_d.port[p].line.strobe = 1'b1;
        state_d.port[p].line.nibble = state_q.port[p].sync1.txd;
        state_d.port[p].line.valid = state_q.port[p].sync1.tx_en;
        // an error flag outside a frame has no symbol to replace, so halt needs enable
        state_d.port[p].line.halt = state_q.port[p].sync1.tx_en
                                    & state_q.port[p].sync1.tx_er;
        state_d.port[p].tx_en = state_q.port[p].sync1.tx_en;
      end
      // receive pins move one core cycle after the falling edge; stable at the rise at the slow rate, moving with the rise at the fast rate
      if (pfall[p]) begin
        state_d.port[p].rx.rxd = i_pcs_rx[p].nibble;
        state_d.port[p].rx.rx_dv = i_pcs_rx[p].data_valid;
        state_d.port[p].rx.rx_er = i_pcs_rx[p].code_bad | ~i_pll_lock[p];
      end
      // carrier is not tied to either clock, so it follows every core cycle
      state_d.port[p].crs = i_pcs_rx[p].active
                            | (~i_full_duplex[p] & state_q.port[p].tx_en);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // straight copies of the state flops, no logic after the registers
  always_comb begin
    for (int p = 0; p < `QPMII_PORTS; p++) begin
      o_mii_rx[p] = state_q.port[p].rx;
      o_line_tx[p] = state_q.port[p].line;
      o_crs[p] = state_q.port[p].crs;
    end
  end

  // both clocks come from the divider flop; the fast rate tops out at half the core clock
  assign o_tx_clk = pclk;
  assign o_rx_clk = pclk;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // checks pause while reset is low; all of them read sampled values

  for (genvar g = 0; g < `QPMII_PORTS; g++) begin : g_chk
    // pin level seen at the edge travels two flops, then lands on the line
    sequence s_rise_seen;
      $rose(o_tx_clk[g]) && !i_late_sample[g] ##1 !i_late_sample[g];
    endsequence
    sequence s_fall_seen;
      $fell(o_tx_clk[g]) && i_late_sample[g] ##1 i_late_sample[g];
    endsequence

    tx_rise_capture_a: assert property (
      s_rise_seen |=> o_line_tx[g].strobe
                      && o_line_tx[g].nibble == $past(i_mii_tx[g].txd, 3))
      else $error("rising edge nibble not captured");
    tx_fall_capture_a: assert property (
      s_fall_seen |=> o_line_tx[g].strobe
                      && o_line_tx[g].nibble == $past(i_mii_tx[g].txd, 3))
      else $error("falling edge nibble not captured");
    tx_idle_off_a: assert property (
      o_line_tx[g].strobe && !$past(i_mii_tx[g].tx_en, 3) |-> !o_line_tx[g].valid
                                                           && !o_line_tx[g].halt)
      else $error("symbol sent without enable");
    tx_halt_code_a: assert property (
      o_line_tx[g].strobe && $past(i_mii_tx[g].tx_en, 3) && $past(i_mii_tx[g].tx_er, 3)
        |-> o_line_tx[g].halt && o_line_tx[g].valid)
      else $error("error not turned into halt");
    slow_clk_half_a: assert property (
      $rose(o_tx_clk[g]) && !$past(i_speed_100[g]) |-> o_tx_clk[g] [*4] ##1 !o_tx_clk[g])
      else $error("10 mbps half period wrong");
    fast_clk_half_a: assert property (
      $changed(o_rx_clk[g]) && $past(i_speed_100[g]) |=> $changed(o_rx_clk[g]))
      else $error("100 mbps half period wrong");
    rx_nibble_move_a: assert property (
      $fell(o_rx_clk[g]) |=> o_mii_rx[g].rxd == $past(i_pcs_rx[g].nibble)
                             && o_mii_rx[g].rx_dv == $past(i_pcs_rx[g].data_valid)
                             ##1 $stable(o_mii_rx[g]))
      else $error("receive nibble not in step with clock");
    rx_error_flag_a: assert property (
      $fell(o_rx_clk[g]) && !i_pll_lock[g] |=> o_mii_rx[g].rx_er)
      else $error("unlocked pll not flagged");
    crs_full_duplex_a: assert property (
      i_full_duplex[g] && !i_pcs_rx[g].active |=> !o_crs[g])
      else $error("carrier raised by transmit in full duplex");
    crs_half_duplex_a: assert property (
      !i_full_duplex[g] && o_line_tx[g].valid |=> o_crs[g])
      else $error("carrier missing while transmitting in half duplex");

    // enabled symbols must carry the valid mark
    tx_valid_enable_a: assert property (
      o_line_tx[g].strobe && $past(i_mii_tx[g].tx_en, 3) |-> o_line_tx[g].valid)
      else $error("enabled symbol not marked valid");
    // no capture in the cycle right after another while the capture mode holds still
    tx_one_strobe_a: assert property (
      o_line_tx[g].strobe && $stable(i_late_sample[g]) |=> !o_line_tx[g].strobe)
      else $error("two captures in a row");
    // low phase of the slow receive clock, mirror of the high phase check
    slow_rx_half_a: assert property (
      $fell(o_rx_clk[g]) && !$past(i_speed_100[g]) |-> !o_rx_clk[g] [*4] ##1 o_rx_clk[g])
      else $error("10 mbps receive low phase wrong");
    // the fast transmit clock toggles on every core cycle
    fast_tx_half_a: assert property (
      $changed(o_tx_clk[g]) && $past(i_speed_100[g]) |=> $changed(o_tx_clk[g]))
      else $error("100 mbps transmit half period wrong");

    // receive outputs move only in the cycle after a receive clock fall
    rx_hold_clock_a: assert property (
      !$fell(o_rx_clk[g]) |=> $stable(o_mii_rx[g]))
      else $error("receive pins moved off the clock");
    // receive error follows a bad code group and is clear without a cause
    rx_error_code_a: assert property (
      $fell(o_rx_clk[g]) && i_pcs_rx[g].code_bad |=> o_mii_rx[g].rx_er)
      else $error("bad code group not flagged");
    rx_error_clear_a: assert property (
      $fell(o_rx_clk[g]) && !i_pcs_rx[g].code_bad && i_pll_lock[g] |=> !o_mii_rx[g].rx_er)
      else $error("receive error raised without cause");
    // the first bit on the medium lands on line zero, the last on line three
    rx_bit_order_a: assert property (
      $fell(o_rx_clk[g]) |=> o_mii_rx[g].rxd[0] == $past(i_pcs_rx[g].nibble[0])
                             && o_mii_rx[g].rxd[3] == $past(i_pcs_rx[g].nibble[3]))
      else $error("receive nibble bit order wrong");

    // receive activity raises carrier in either duplex mode
    crs_receive_a: assert property (
      i_pcs_rx[g].active |=> o_crs[g])
      else $error("carrier missing while receiving");
  end

endmodule // qpmii_top

// file: sim/qpmii_mac_model.sv
// ************************************************************
// mac transmit side model, one port
// ************************************************************
module qpmii_mac_model (
  // core clock
  input wire logic i_clk,
  // port clock and capture mode from the phy
  input wire logic i_tx_clk,
  input wire logic i_late,
  // value the bench wants on the pins next
  input wire qpmii_pkg::qpmii_mii_tx_t i_next,
  // mac transmit pins
  output qpmii_pkg::qpmii_mii_tx_t o_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  import qpmii_pkg::*;
  logic clk_q = 1'b0;
  initial o_tx = '0;
  // launch on the edge opposite the capture edge so the phy never sees pins mid-change
  always @(posedge i_clk) begin
    if (i_late ? (!clk_q && i_tx_clk) : (clk_q && !i_tx_clk)) begin
      o_tx <= i_next;
    end
    clk_q <= i_tx_clk;
  end
endmodule // qpmii_mac_model

// file: sim/tb_quad_phy_mii_data_port.sv
module tb_quad_phy_mii_data_port;
  timeunit 1ns;
  timeprecision 1ps;
  import qpmii_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_speed_100 = '0;
  logic [3:0] i_full_duplex = '0;
  logic [3:0] i_late_sample = '0;
  logic [3:0] i_pll_lock = '1;
  wire qpmii_mii_tx_t [3:0] mii_tx;
  qpmii_mii_tx_t [3:0] mac_next = '0;
  qpmii_pcs_rx_t [3:0] i_pcs_rx = '0;
  logic [3:0] o_tx_clk, o_rx_clk, o_crs;
  qpmii_mii_rx_t [3:0] o_mii_rx;
  qpmii_line_tx_t [3:0] o_line_tx;
  int failures = 0;
  int comparisons = 0;

  qpmii_top DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_speed_100(i_speed_100),
    .i_full_duplex(i_full_duplex), .i_late_sample(i_late_sample), .i_mii_tx(mii_tx),
    .o_tx_clk(o_tx_clk), .o_mii_rx(o_mii_rx), .o_rx_clk(o_rx_clk), .o_crs(o_crs),
    .o_line_tx(o_line_tx), .i_pcs_rx(i_pcs_rx), .i_pll_lock(i_pll_lock));

  // one mac per port, each locked to its own port clock
  for (genvar g = 0; g < 4; g++) begin : g_mac
    qpmii_mac_model MAC (.i_clk(i_clk), .i_tx_clk(o_tx_clk[g]), .i_late(i_late_sample[g]),
      .i_next(mac_next[g]), .o_tx(mii_tx[g]));
  end

  // 20 mhz core clock
  initial begin
    forever #25 i_clk = ~i_clk;
  end

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for a port clock level, counting cycles; receive clock must track it
  task automatic wait_lvl(input int p, input logic lvl, inout int n);
    while (o_tx_clk[p] !== lvl) begin
      check({7'h0, o_rx_clk[p]}, {7'h0, o_tx_clk[p]});
      n++;
      if (n > 100) begin
        failures++;
        end_sim();
      end
      @(posedge i_clk);
    end
  endtask

  task automatic wait_strobe(input int p);
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_line_tx[p].strobe !== 1'b1) begin
      n++;
      if (n > 100) begin
        failures++;
        end_sim();
      end
      @(posedge i_clk);
    end
  endtask

  // clock period in core cycles: 8 at the slow rate, 2 where the fast rate floors
  task automatic clk_case(input int p, input logic spd);
    int n;
    i_speed_100[p] <= spd;
    repeat (20) @(posedge i_clk);
    n = 0;
    wait_lvl(p, 1'b0, n);
    wait_lvl(p, 1'b1, n);
    n = 0;
    wait_lvl(p, 1'b0, n);
    wait_lvl(p, 1'b1, n);
    check(8'(n), spd ? 8'h02 : 8'h08);
  endtask

  // pins held steady, so the third capture must carry them; the slow-rate clock level at
  // the strobe tells which edge captured
  task automatic tx_case(input int p, input logic spd, input logic late, input qpmii_mii_tx_t v);
    mac_next[p] <= v;
    i_speed_100[p] <= spd;
    i_late_sample[p] <= late;
    repeat (3) wait_strobe(p);
    check({2'h0, o_line_tx[p].valid, o_line_tx[p].halt, o_line_tx[p].nibble},
      {2'h0, v.tx_en, v.tx_en & v.tx_er, v.txd});
    if (!spd) check({7'h0, o_tx_clk[p]}, {7'h0, ~late});
    repeat (2) @(posedge i_clk);
    check({7'h0, o_crs[p]}, {7'h0, v.tx_en});
  endtask

  // receive path and carrier under a given duplex, lock and transmit activity
  task automatic rx_case(input int p, input logic full, input logic en, input logic lock,
      input qpmii_pcs_rx_t r);
    i_full_duplex[p] <= full;
    i_pll_lock[p] <= lock;
    i_pcs_rx[p] <= r;
    mac_next[p] <= {4'h0, en, 1'b0};
    repeat (30) @(posedge i_clk);
    check({2'h0, o_mii_rx[p]}, {2'h0, r.nibble, r.data_valid, r.code_bad | ~lock});
    check({7'h0, o_crs[p]}, {7'h0, r.active | (~full & en)});
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      clk_case(p, 1'b0);
      clk_case(p, 1'b1);
      tx_case(p, 1'b0, 1'b0, {4'h5, 1'b1, 1'b0});
      tx_case(p, 1'b0, 1'b1, {4'ha, 1'b1, 1'b1});
      tx_case(p, 1'b1, 1'b0, {4'h3, 1'b0, 1'b1});
      tx_case(p, 1'b1, 1'b1, {4'hc, 1'b1, 1'b0});
      i_speed_100[p] <= 1'b0;
      i_late_sample[p] <= 1'b0;
      rx_case(p, 1'b0, 1'b1, 1'b1, {4'h9, 1'b1, 1'b0, 1'b0});
      rx_case(p, 1'b1, 1'b1, 1'b0, {4'h6, 1'b0, 1'b0, 1'b0});
      rx_case(p, 1'b1, 1'b0, 1'b1, {4'he, 1'b0, 1'b1, 1'b1});
    end
    end_sim();
  end
endmodule // tb_quad_phy_mii_data_port
